//--- logic/tmrv_pkg.sv
// constants, field layout and types of the compare-match timer
package tmrv_pkg;
   // =====================================================================
   // register word indices on the bus
   localparam logic [2:0] TMRV_IDX_MAIN   = 3'h0;
   localparam logic [2:0] TMRV_IDX_CONSTA = 3'h1;
   localparam logic [2:0] TMRV_IDX_CONSTB = 3'h2;
   localparam logic [2:0] TMRV_IDX_COUNT  = 3'h3;
   localparam logic [2:0] TMRV_IDX_FLAGS  = 3'h4;
   localparam logic [2:0] TMRV_IDX_TRIG   = 3'h5;
   // =====================================================================
   // status register fields
   localparam int TMRV_FLAG_B_BIT    = 7;
   localparam int TMRV_FLAG_A_BIT    = 6;
   localparam int TMRV_WRAP_BIT      = 5;
   localparam int TMRV_ACT_B_LSB     = 2;
   localparam int TMRV_ACT_A_LSB     = 0;
   localparam logic [7:0] TMRV_FLAGS_RSV = 8'h10;
   // main control fields
   localparam int TMRV_IEN_LSB       = 5;  // b, a, wrap enables 7..5
   localparam int TMRV_CLR_LSB       = 3;
   localparam int TMRV_CKS_LSB       = 0;
   // trigger config fields
   localparam int TMRV_EDGE_LSB      = 3;
   localparam int TMRV_TRIGGER_START_ENABLE_BIT      = 2;
   localparam int TMRV_PAIR_BIT      = 0;
   localparam logic [7:0] TMRV_TRIG_RSV  = 8'he2;
   // =====================================================================
   // reset values
   localparam logic [7:0] TMRV_CONST_RST = 8'hff;
   localparam logic [7:0] TMRV_COUNT_RST = 8'h00;
   localparam logic [7:0] TMRV_COUNT_MAX = 8'hff;
   localparam logic [7:0] TMRV_REG_RST   = 8'h00;
   // =====================================================================
   // codes
   typedef enum logic [1:0] {
      TMRV_ACT_NONE, TMRV_ACT_LOW, TMRV_ACT_HIGH, TMRV_ACT_TOGGLE
   } tmrv_act_t;
   typedef enum logic [1:0] {
      TMRV_CLR_OFF, TMRV_CLR_MATCH_A, TMRV_CLR_MATCH_B, TMRV_CLR_PIN
   } tmrv_clr_t;
   localparam logic [1:0] TMRV_EDGE_RISE = 2'h1;
   localparam logic [1:0] TMRV_EDGE_FALL = 2'h2;
   localparam int TMRV_DIV_BITS = 7;      // phi/128 is the slowest tap
   typedef enum logic [1:0] {
      TMRV_BUS_IDLE, TMRV_BUS_DONE
   } tmrv_bus_t;
endpackage

//--- logic/tmrv_prescale.sv
// prescaler and count-tick generator
`timescale 1ns/10ps
module tmrv_prescale
   import tmrv_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // tick request and answer
   tmrv_tick_if.presc tk
);
   logic [TMRV_DIV_BITS-1:0] div_r;
   logic                     tap_prev_r;
   logic                     ext_prev_r;
   logic                     tap;
   logic                     ext_rise;
   logic                     ext_fall;

   // =====================================================================
   // free-running divider of the system clock
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // pick the tap: code 001 gives phi/4 or phi/8, 011 phi/64 or phi/128
   always_comb begin
      tap = 1'b0;
      case (tk.clk_sel)
         3'h1: tap = tk.pair_sel ? div_r[2] : div_r[1];
         3'h2: tap = tk.pair_sel ? div_r[4] : div_r[3];
         3'h3: tap = tk.pair_sel ? div_r[6] : div_r[5];
         default: tap = 1'b0;
      endcase
   end

   // remember the previous tap and external levels for edge detection;
   // a switch from a high tap to a low one counts once, as on the part
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tap_prev_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end else begin
         tap_prev_r <= tap;
         ext_prev_r <= tk.ext_clk;
      end
   end

   assign ext_rise = tk.ext_clk & ~ext_prev_r;
   assign ext_fall = ~tk.ext_clk & ext_prev_r;

   // tick on falling tap edge or the chosen external edge
   always_comb begin
      case (tk.clk_sel)
         3'h1, 3'h2, 3'h3: tk.tick = tap_prev_r & ~tap;
         3'h5:    tk.tick = ext_rise;
         3'h6:    tk.tick = ext_fall;
         3'h7:    tk.tick = ext_rise | ext_fall;
         default: tk.tick = 1'b0;          // clock input prohibited
      endcase
   end
endmodule

//--- logic/tmrv_tick_if.sv
// clock-select and count-tick signals between timer and prescaler
`timescale 1ns/10ps
interface tmrv_tick_if;
   logic [2:0] clk_sel;      // three-bit clock select field
   logic       pair_sel;     // picks the slower tap of each pair
   logic       ext_clk;      // synchronised external clock level
   logic       tick;         // one-cycle count pulse
   modport timer (output clk_sel, output pair_sel, output ext_clk,
                  input tick);
   modport presc (input clk_sel, input pair_sel, input ext_clk,
                  output tick);
endinterface

//--- logic/tmrv_top.sv
// eight-bit compare-match timer with flags, pin actions and trigger
`timescale 1ns/10ps
module tmrv_top
   import tmrv_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // pins
   input  wire logic        trigger_in_pin,
   input  wire logic        ext_clock_pin,
   input  wire logic        ext_reset_pin,
   output logic             waveform_out_pin,
   // interrupt requests: b, a, wrap
   output logic             match_b_irq,
   output logic             match_a_irq,
   output logic             wrap_irq
);
   // =====================================================================
   // declarations
   tmrv_tick_if tk ();

   tmrv_bus_t   bus_r;
   logic [31:0] rdata_r;
   logic [7:0]  main_r;
   logic [7:0]  const_a_r;
   logic [7:0]  const_b_r;
   logic [7:0]  count_r;
   logic [4:0]  trig_r;        // edge 4:3, enable 2, bit 0 pair select
   logic [1:0]  act_b_r;
   logic [1:0]  act_a_r;
   logic [2:0]  flag_r;        // index 2 b, 1 a, 0 wrap
   logic [2:0]  armed_r;       // flag was read as 1
   logic        wave_r;
   logic        run_r;
   logic [2:0]  sync1_r;
   logic [2:0]  sync2_r;
   logic [2:0]  sync3_r;
   logic [2:0]  irq_r;

   logic        wr_go;
   logic        rd_go;
   logic        wr_main;
   logic        wr_consta;
   logic        wr_constb;
   logic        wr_count;
   logic        wr_flags;
   logic        wr_trig;
   logic [7:0]  wdat;
   logic [7:0]  rsel;
   logic        hit;
   logic        match_a;
   logic        match_b;
   logic        pin_clear;
   logic        clear_ev;
   logic        wrap_ev;
   logic [2:0]  set_ev;
   logic        trg_rise;
   logic        trg_fall;
   logic        trg_edge;
   tmrv_clr_t   clr_mode;
   logic [1:0]  edge_sel;
   logic        any_tog;
   logic        any_hi;
   logic        any_lo;

   // =====================================================================
   // pin synchronisers: trigger 0, external clock 1, external reset 2
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               sync1_r[gp] <= 1'b0;
               sync2_r[gp] <= 1'b0;
               sync3_r[gp] <= 1'b0;
            end else begin
               sync1_r[gp] <= (gp == 0) ? trigger_in_pin :
                              (gp == 1) ? ext_clock_pin : ext_reset_pin;
               sync2_r[gp] <= sync1_r[gp];
               sync3_r[gp] <= sync2_r[gp];   // previous level for edges
            end
         end
      end
   endgenerate

   // =====================================================================
   // bus slave: one wait cycle, then the access completes
   assign avs_waitrequest = (avs_read | avs_write) & (bus_r == TMRV_BUS_IDLE);
   assign wr_go = avs_write & (bus_r == TMRV_BUS_DONE);
   assign rd_go = avs_read & (bus_r == TMRV_BUS_DONE);
   assign wdat  = avs_writedata[7:0];
   assign avs_readdata = rdata_r;

   // address decode of writes
   always_comb begin
      wr_main   = 1'b0;
      wr_consta = 1'b0;
      wr_constb = 1'b0;
      wr_count  = 1'b0;
      wr_flags  = 1'b0;
      wr_trig   = 1'b0;
      if (avs_address == TMRV_IDX_MAIN) begin
         wr_main = wr_go;
      end else if (avs_address == TMRV_IDX_CONSTA) begin
         wr_consta = wr_go;
      end else if (avs_address == TMRV_IDX_CONSTB) begin
         wr_constb = wr_go;
      end else if (avs_address == TMRV_IDX_COUNT) begin
         wr_count = wr_go;
      end else if (avs_address == TMRV_IDX_FLAGS) begin
         wr_flags = wr_go;
      end else if (avs_address == TMRV_IDX_TRIG) begin
         wr_trig = wr_go;
      end
   end

   // read mux; unmapped words read zero
   always_comb begin
      rsel = 8'h00;
      if (avs_address == TMRV_IDX_MAIN) begin
         rsel = main_r;
      end else if (avs_address == TMRV_IDX_CONSTA) begin
         rsel = const_a_r;
      end else if (avs_address == TMRV_IDX_CONSTB) begin
         rsel = const_b_r;
      end else if (avs_address == TMRV_IDX_COUNT) begin
         rsel = count_r;
      end else if (avs_address == TMRV_IDX_FLAGS) begin
         rsel = {flag_r, 1'b0, act_b_r, act_a_r} | TMRV_FLAGS_RSV;
      end else if (avs_address == TMRV_IDX_TRIG) begin
         rsel = {3'h0, trig_r} | TMRV_TRIG_RSV;
      end
   end

   // handshake state and registered read data
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus_r   <= TMRV_BUS_IDLE;
         rdata_r <= 32'h0000_0000;
      end else if (bus_r == TMRV_BUS_IDLE) begin
         if (avs_read | avs_write) begin
            bus_r <= TMRV_BUS_DONE;
         end
         if (avs_read) begin
            rdata_r <= {24'h00_0000, rsel};
         end
      end else begin
         bus_r <= TMRV_BUS_IDLE;
      end
   end

   // =====================================================================
   // plain control registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         main_r    <= TMRV_REG_RST;
         const_a_r <= TMRV_CONST_RST;
         const_b_r <= TMRV_CONST_RST;
         trig_r    <= TMRV_REG_RST[4:0];
         act_b_r   <= 2'h0;
         act_a_r   <= 2'h0;
      end else begin
         if (wr_main) main_r <= wdat;
         if (wr_consta) const_a_r <= wdat;
         if (wr_constb) const_b_r <= wdat;
         if (wr_trig) trig_r <= wdat[4:0];
         if (wr_flags) begin
            act_b_r <= wdat[TMRV_ACT_B_LSB +: 2];
            act_a_r <= wdat[TMRV_ACT_A_LSB +: 2];
         end
      end
   end

   assign clr_mode = tmrv_clr_t'(main_r[TMRV_CLR_LSB +: 2]);
   assign edge_sel = trig_r[TMRV_EDGE_LSB +: 2];

   // =====================================================================
   // prescaler
   assign tk.clk_sel  = main_r[TMRV_CKS_LSB +: 3];
   assign tk.pair_sel = trig_r[TMRV_PAIR_BIT];
   assign tk.ext_clk  = sync2_r[1];

   tmrv_prescale u_presc (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tk      (tk)
   );

   // =====================================================================
   // compare events; a write to a constant suppresses its match
   assign hit     = tk.tick & run_r;
   assign match_a = hit & (count_r == const_a_r) & ~wr_consta;
   assign match_b = hit & (count_r == const_b_r) & ~wr_constb;
   assign pin_clear = sync2_r[2] & ~sync3_r[2];
   always_comb begin
      case (clr_mode)
         TMRV_CLR_MATCH_A: clear_ev = match_a;
         TMRV_CLR_MATCH_B: clear_ev = match_b;
         TMRV_CLR_PIN:     clear_ev = pin_clear;
         default:          clear_ev = 1'b0;
      endcase
   end
   assign wrap_ev = hit & (count_r == TMRV_COUNT_MAX) & ~clear_ev;
   assign set_ev  = {match_b, match_a, wrap_ev};

   // counter: clear beats a bus write, a bus write beats a count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_r <= TMRV_COUNT_RST;
      end else if (clear_ev) begin
         count_r <= TMRV_COUNT_RST;
      end else if (wr_count) begin
         count_r <= wdat;
      end else if (hit) begin
         count_r <= count_r + 8'h01;
      end
   end

   // =====================================================================
   // trigger edge and run control
   assign trg_rise = sync2_r[0] & ~sync3_r[0];
   assign trg_fall = ~sync2_r[0] & sync3_r[0];
   assign trg_edge = (edge_sel[0] & trg_rise) | (edge_sel[1] & trg_fall);

   // the counter parks after a clear only while trigger start is enabled
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         run_r <= 1'b1;
      end else if (!trig_r[TMRV_TRIGGER_START_ENABLE_BIT]) begin
         run_r <= 1'b1;
      end else if (clear_ev) begin
         run_r <= 1'b0;
      end else if (trg_edge) begin
         run_r <= 1'b1;
      end
   end

   // =====================================================================
   // status flags: set wins over the read-then-write-0 clear
   genvar gf;
   generate
      for (gf = 0; gf < 3; gf++) begin : g_flag
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               flag_r[gf]  <= 1'b0;
               armed_r[gf] <= 1'b0;
            end else begin
               if (set_ev[gf]) begin
                  flag_r[gf] <= 1'b1;
               end else if (wr_flags && !wdat[TMRV_WRAP_BIT + gf] &&
                            armed_r[gf]) begin
                  flag_r[gf] <= 1'b0;
               end
               // arm from the value the reader was shown: a flag set
               // during the wait cycle was read as 0 and stays armed-off
               if (rd_go && avs_address == TMRV_IDX_FLAGS) begin
                  armed_r[gf] <= rdata_r[TMRV_WRAP_BIT + gf];
               end else if (wr_flags) begin
                  armed_r[gf] <= 1'b0;       // one clear per read
               end
            end
         end
      end
   endgenerate

   // =====================================================================
   // interrupt requests, registered so they are glitch free
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_r <= 3'h0;
      end else begin
         irq_r <= flag_r & main_r[TMRV_IEN_LSB +: 3];
      end
   end
   assign match_b_irq = irq_r[2];
   assign match_a_irq = irq_r[1];
   assign wrap_irq    = irq_r[0];

   // =====================================================================
   // waveform pin: each match applies its own action, merged by priority
   always_comb begin
      any_tog = (match_a && act_a_r == TMRV_ACT_TOGGLE) ||
                (match_b && act_b_r == TMRV_ACT_TOGGLE);
      any_hi  = (match_a && act_a_r == TMRV_ACT_HIGH) ||
                (match_b && act_b_r == TMRV_ACT_HIGH);
      any_lo  = (match_a && act_a_r == TMRV_ACT_LOW) ||
                (match_b && act_b_r == TMRV_ACT_LOW);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wave_r <= 1'b0;
      end else if (any_tog) begin
         wave_r <= ~wave_r;
      end else if (any_hi) begin
         wave_r <= 1'b1;
      end else if (any_lo) begin
         wave_r <= 1'b0;
      end
   end
   assign waveform_out_pin = wave_r;
endmodule

//--- verif/tmrv_pin_model.sv
// pin partner: trigger source, external count clock and output load
`timescale 1ns/10ps
module tmrv_pin_model (
   // clock
   input wire logic ref_clk,
   // pins
   output logic     trigger_in_pin,
   output logic     ext_clock_pin,
   output logic     ext_reset_pin,
   input wire logic waveform_out_pin
);
   // idle levels; the count clock stands still between ticks
   initial begin
      trigger_in_pin = 1'b0;
      ext_clock_pin = 1'b0;
      ext_reset_pin = 1'b0;
   end
   // each phase held 4 cycles so the synchroniser cannot miss it
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         ext_clock_pin <= 1'b1;
         repeat (4) @(posedge ref_clk);
         ext_clock_pin <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
      @(negedge ref_clk);
   endtask
   // counter clear pulse, wide enough for the synchroniser to see
   task automatic pulse_reset;
      @(posedge ref_clk);
      ext_reset_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_reset_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // trigger level change, then room for the synchroniser delay
   task automatic set_trig(input logic v);
      @(posedge ref_clk);
      trigger_in_pin <= v;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
endmodule

//--- verif/tmrv_props.sv
// checker for the timer bus handshake, readback and pin behaviour
`timescale 1ns/10ps
module tmrv_props (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // register bus
   input wire logic [2:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // pin and requests
   input wire logic        waveform_out_pin,
   input wire logic        match_b_irq,
   input wire logic        match_a_irq,
   input wire logic        wrap_irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // read completing at this edge
   wire logic rd_done = avs_read && !avs_waitrequest;
   // ==========
   // bus handshake: exactly one wait cycle per access
   property p_wait_first;
      $rose(avs_read || avs_write) |-> avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first)
      else $error("request not stalled in its first cycle");
   property p_wait_once;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_once: assert property (p_wait_once)
      else $error("more than one wait cycle");
   // read data holds between reads
   property p_rd_hold;
      !avs_read |=> $stable(avs_readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");
   property p_rd_upper;
      rd_done |-> avs_readdata[31:8] == 24'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("upper read data not zero");
   // ==========
   // reserved bits and unmapped words
   property p_flags_rsv;
      rd_done && avs_address == 3'h4 |-> avs_readdata[4];
   endproperty
   a_flags_rsv: assert property (p_flags_rsv)
      else $error("status reserved bit read 0");
   property p_trig_rsv;
      rd_done && avs_address == 3'h5 |->
         avs_readdata[7:5] == 3'h7 && avs_readdata[1];
   endproperty
   a_trig_rsv: assert property (p_trig_rsv)
      else $error("trigger config reserved bit read 0");
   property p_unmapped;
      rd_done && avs_address[2:1] == 2'h3 |-> avs_readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped word read not zero");
   // ==========
   // pin low after reset; no counting source selected yet
   property p_pin_reset;
      $fell(rst) |-> !waveform_out_pin [*3];
   endproperty
   a_pin_reset: assert property (p_pin_reset)
      else $error("waveform pin high after reset");
   // a request needs its enable, seen through a control read
   property p_irq_gate;
      rd_done && avs_address == 3'h0 |=>
         (avs_readdata[7] || !match_b_irq) &&
         (avs_readdata[6] || !match_a_irq) &&
         (avs_readdata[5] || !wrap_irq);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt request with enable clear");
endmodule
bind tmrv_top tmrv_props u_props (
   .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .waveform_out_pin(waveform_out_pin), .match_b_irq(match_b_irq),
   .match_a_irq(match_a_irq), .wrap_irq(wrap_irq));

//--- verif/tmrv_top_tb.sv
// self-checking bench for the compare-match timer
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tmrv_top_tb
   import tmrv_pkg::*;
;
   logic        ref_clk;
   logic        rst;
   logic [2:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        trigger_in_pin, ext_clock_pin, ext_reset_pin;
   logic        waveform_out_pin, match_b_irq, match_a_irq, wrap_irq;
   int          mismatches = 0;
   int          checks = 0;
   always #5 ref_clk = ~ref_clk;
   tmrv_top u_dut (.ref_clk(ref_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .trigger_in_pin(trigger_in_pin), .ext_clock_pin(ext_clock_pin),
      .ext_reset_pin(ext_reset_pin), .waveform_out_pin(waveform_out_pin),
      .match_b_irq(match_b_irq), .match_a_irq(match_a_irq),
      .wrap_irq(wrap_irq));
   tmrv_pin_model u_pins (.ref_clk(ref_clk),
      .trigger_in_pin(trigger_in_pin), .ext_clock_pin(ext_clock_pin),
      .ext_reset_pin(ext_reset_pin), .waveform_out_pin(waveform_out_pin));
   // ==========
   // verdict and end of run
   task automatic final_report;
      if (mismatches == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // one access; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic we, input logic [2:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
      int n;
      @(posedge ref_clk);
      avs_address   <= a;
      avs_read      <= !we;
      avs_write     <= we;
      avs_writedata <= {24'h0, wd};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      `CHK(n < 20, 1'b1)
      rd = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] v;
      bus(1'b0, a, 8'h00, v);
      `CHK(v, e)
   endtask
   // ==========
   // reset values, reserved bits, unmapped words
   task automatic s_reset;
      rd_chk(TMRV_IDX_MAIN, TMRV_REG_RST);
      rd_chk(TMRV_IDX_CONSTB, TMRV_CONST_RST);
      rd_chk(TMRV_IDX_FLAGS, 8'h10);
      rd_chk(TMRV_IDX_TRIG, 8'he2);
      `CHK(waveform_out_pin, 1'b0)
      wr(TMRV_IDX_TRIG, 8'hff);
      rd_chk(TMRV_IDX_TRIG, 8'hff);
      wr(TMRV_IDX_TRIG, 8'h00);
      rd_chk(TMRV_IDX_TRIG, 8'he2);
      wr(TMRV_IDX_FLAGS, 8'hff);
      rd_chk(TMRV_IDX_FLAGS, 8'h1f);
      wr(TMRV_IDX_FLAGS, 8'h00);
      wr(3'h6, 8'h5a);
      rd_chk(3'h6, 8'h00);
   endtask
   // flags set by matches and wrap, pin actions, read-then-clear
   task automatic s_flags;
      wr(TMRV_IDX_CONSTA, 8'h03);
      wr(TMRV_IDX_CONSTB, 8'h05);
      wr(TMRV_IDX_FLAGS, 8'h06);
      wr(TMRV_IDX_MAIN, 8'h05);
      u_pins.tick(3);
      rd_chk(TMRV_IDX_FLAGS, 8'h16);
      u_pins.tick(1);
      `CHK(waveform_out_pin, 1'b1)
      rd_chk(TMRV_IDX_FLAGS, 8'h56);
      u_pins.tick(2);
      `CHK(waveform_out_pin, 1'b0)
      rd_chk(TMRV_IDX_FLAGS, 8'hd6);
      wr(TMRV_IDX_MAIN, 8'he5);
      repeat (2) @(negedge ref_clk);
      `CHK({match_b_irq, match_a_irq, wrap_irq}, 3'h6)
      wr(TMRV_IDX_MAIN, 8'h05);
      repeat (2) @(negedge ref_clk);
      `CHK({match_b_irq, match_a_irq}, 2'h0)
      wr(TMRV_IDX_FLAGS, 8'h86);
      wr(TMRV_IDX_FLAGS, 8'h06);
      rd_chk(TMRV_IDX_FLAGS, 8'h96);
      wr(TMRV_IDX_FLAGS, 8'h06);
      rd_chk(TMRV_IDX_FLAGS, 8'h16);
      wr(TMRV_IDX_COUNT, 8'hff);
      u_pins.tick(1);
      rd_chk(TMRV_IDX_FLAGS, 8'h36);
      rd_chk(TMRV_IDX_COUNT, 8'h00);
   endtask
   // both matches in one tick; toggle over 1 over 0
   task automatic s_prio;
      logic [7:0] acts [8] = '{8'h05, 8'h07, 8'h06, 8'h05,
                               8'h0d, 8'h0c, 8'h08, 8'h0e};
      logic outs [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      wr(TMRV_IDX_CONSTA, 8'h08);
      wr(TMRV_IDX_CONSTB, 8'h08);
      foreach (acts[k]) begin
         wr(TMRV_IDX_FLAGS, acts[k]);
         wr(TMRV_IDX_COUNT, 8'h08);
         u_pins.tick(1);
         `CHK(waveform_out_pin, outs[k])
      end
   endtask
   // halt on match clear, resume on the chosen trigger edge
   task automatic s_trig;
      logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      logic [1:0] c;
      wr(TMRV_IDX_CONSTA, 8'h02);
      wr(TMRV_IDX_MAIN, 8'h0d);
      foreach (codes[k]) begin
         c = codes[k];
         wr(TMRV_IDX_TRIG, {3'h0, c, 3'h4});
         wr(TMRV_IDX_COUNT, 8'h00);
         u_pins.tick(4);
         rd_chk(TMRV_IDX_COUNT, 8'h00);
         u_pins.set_trig(1'b1);
         u_pins.tick(1);
         rd_chk(TMRV_IDX_COUNT, {7'h0, c[0]});
         u_pins.set_trig(1'b0);
         u_pins.tick(1);
         rd_chk(TMRV_IDX_COUNT, c[0] ? 8'h02 : {7'h0, c[1]});
      end
      wr(TMRV_IDX_TRIG, 8'h00);
      wr(TMRV_IDX_COUNT, 8'h00);
      u_pins.set_trig(1'b1);
      u_pins.tick(4);
      rd_chk(TMRV_IDX_COUNT, 8'h01);
   endtask
   // internal taps: a switch may add one tick, hence the margin
   task automatic s_presc;
      logic [7:0] v;
      logic [7:0] e;
      for (int i = 0; i < 6; i++) begin
         wr(TMRV_IDX_TRIG, {7'h0, i[0]});
         wr(TMRV_IDX_MAIN, {5'h0, 3'(i / 2 + 1)});
         wr(TMRV_IDX_COUNT, 8'h00);
         repeat (256) @(posedge ref_clk);
         bus(1'b0, TMRV_IDX_COUNT, 8'h00, v);
         e = 8'(256 >> (i + 2));
         `CHK((v >= e - 8'h01) && (v <= e + 8'h02), 1'b1)
      end
   endtask
   // external falling and both-edge counting, pin clear halts the count
   task automatic s_ext;
      u_pins.set_trig(1'b0);
      wr(TMRV_IDX_TRIG, 8'h0c);
      wr(TMRV_IDX_MAIN, 8'h1e);
      wr(TMRV_IDX_COUNT, 8'h00);
      u_pins.tick(3);
      rd_chk(TMRV_IDX_COUNT, 8'h03);
      u_pins.pulse_reset;
      rd_chk(TMRV_IDX_COUNT, 8'h00);
      u_pins.tick(2);
      rd_chk(TMRV_IDX_COUNT, 8'h00);
      u_pins.set_trig(1'b1);
      wr(TMRV_IDX_MAIN, 8'h1f);
      u_pins.tick(1);
      rd_chk(TMRV_IDX_COUNT, 8'h02);
   endtask
   // ==========
   // main sequence and watchdog
   initial begin
      ref_clk       = 1'b0;
      rst           = 1'b1;
      avs_address   = 3'h0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      s_reset;
      s_flags;
      s_prio;
      s_trig;
      s_presc;
      s_ext;
      final_report;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      final_report;
   end
endmodule
